// *** rtl/seg_link_pkg.sv ***
// constants, field layouts and types of the output segment receiver
// assumes one clock domain; byte n of an image sits at bits 8n+7:8n
package seg_link_pkg;
    // image geometry
    localparam int IMG_BYTES   = 8;
    localparam int PAYLOAD_MAX = 6;
    localparam int FLUSH_BYTE  = 6;
    localparam int CTRL_BYTE   = 7;
    // flush byte bit positions
    localparam int TXF_BIT = 0;
    localparam int RXF_BIT = 1;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_EVT  = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_INFO = 8'h0C;
    // event bits in status and mask
    localparam int EV_LOSS    = 0;
    localparam int EV_DISTURB = 1;
    localparam int EV_TXFLUSH = 2;
    localparam int EV_RXFLUSH = 3;
    localparam int EV_W       = 4;
    // info register field positions
    localparam int INFO_FILL_LSB = 0;
    localparam int INFO_OACK_LSB = 16;
    localparam int INFO_STAT_BIT = 20;
    localparam int INFO_BUSY_BIT = 24;
    // reset values
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [3:0] MASK_RST    = 4'h0;
    localparam logic       STAT_RST    = 1'b1;
    // control byte of the output image
    typedef struct packed {
        logic       srst;
        logic [1:0] iack;
        logic [1:0] ocnt;
        logic [2:0] vcnt;
    } ctrl_byte_t;
    // status byte of the input image
    typedef struct packed {
        logic       stat;
        logic [1:0] oack;
        logic [1:0] icnt;
        logic [2:0] ibytes;
    } stat_byte_t;
    // segment loader states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10
    } seg_state_t;
endpackage

// *** rtl/seg_link.sv ***
// receiver of segmented output images, transmit buffer and input image
// assumes OUT_IMAGE_I is a level held by the gateway, classic wishbone
//
// What this block does
// - an output image is eight bytes: six payload, one flush byte, one control byte.
// - valid payload of each accepted segment goes into the transmit buffer, up to a falling status reset bit that ends the load.
// - receive flush set and a falling status reset bit clears the receive buffer.
// - transmit flush set and a falling status reset bit empties the transmit buffer.
// - flush requests are ignored while status reset is low, high or rising.
// - a falling status reset bit restores the communication status bit to 1 unless a fault occurs in the same cycle.
// - while status reset is 0 changes of count, counter and acknowledge are ignored.
// - a gap in the output segment counter sequence is flagged as segment loss.
// - the valid byte count tells how many payload bytes count, at most six.
// - after accepting a segment its counter is returned as output segment ack.
// - a disturbed serial link clears the communication status bit.
// - each input segment carries an input segment counter stepping 0..3.
`timescale 1ns/1ns
`default_nettype none
module seg_link
    import seg_link_pkg::*;
#(
    parameter int DEPTH = 128
)(
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        STB_I,
    input  wire logic        CYC_I,
    output logic             ACK_O,
    input  wire logic [63:0] OUT_IMAGE_I,
    input  wire logic        IN_SEG_I,
    input  wire logic [47:0] IN_DATA_I,
    input  wire logic [2:0]  IN_COUNT_I,
    input  wire logic        COMM_FAULT_I,
    output logic      [7:0]  TX_DATA_O,
    output logic             TX_VALID_O,
    input  wire logic        TX_READY_I,
    output logic             RX_FLUSH_O,
    output logic      [63:0] IN_IMAGE_O,
    output logic             IRQ_O
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int AW = $clog2(DEPTH);
    localparam logic [CW-1:0] ROOM = CW'(DEPTH - PAYLOAD_MAX);

    // buffer must hold two whole segments and wrap on a power of two
    if (DEPTH < 2 * PAYLOAD_MAX || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 12");
    end

    ////////////////////////////////////////////////////////////////////////
    // image unpacking
    ctrl_byte_t ctrl;
    logic       txf;
    logic       rxf;
    logic       fall;
    assign ctrl = ctrl_byte_t'(OUT_IMAGE_I[8*CTRL_BYTE +: 8]);
    assign txf  = OUT_IMAGE_I[8*FLUSH_BYTE + TXF_BIT];
    assign rxf  = OUT_IMAGE_I[8*FLUSH_BYTE + RXF_BIT];

    ////////////////////////////////////////////////////////////////////////
    // status reset edge, communication status and flushes
    logic srst_prev_ff;
    logic stat_ff;
    logic rxfl_ff;
    logic nxt_stat;
    assign fall = srst_prev_ff & ~ctrl.srst; // only the falling edge acts

    // a fault in the same cycle as the restore wins: the link is still bad
    always_comb
    begin
        nxt_stat = stat_ff;
        if (COMM_FAULT_I)
            nxt_stat = 1'b0;
        else if (fall)
            nxt_stat = 1'b1;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!NRST_I)
        begin
            srst_prev_ff <= 1'b0;
            stat_ff      <= STAT_RST;
            rxfl_ff      <= 1'b0;
        end
        else
        begin
            srst_prev_ff <= ctrl.srst;
            stat_ff      <= nxt_stat;
            rxfl_ff      <= fall & rxf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // segment loader
    seg_state_t     state_ff, nxt_state;
    logic [47:0]    seg_ff, nxt_seg;
    logic [2:0]     len_ff, nxt_len;
    logic [2:0]     idx_ff, nxt_idx;
    logic [1:0]     cnt_ff, nxt_cnt;
    logic [1:0]     oack_ff, nxt_oack;
    logic           sync_ff, nxt_sync;
    logic           accept;
    logic           loss;
    logic           wr;
    logic [2:0]     vlen;
    logic           en_ff;
    logic [CW-1:0]  fill_ff;

    // a count above six is clamped: only six payload bytes exist
    assign vlen   = (ctrl.vcnt > 3'(PAYLOAD_MAX)) ? 3'(PAYLOAD_MAX) : ctrl.vcnt;
    // a new segment is a counter change, or any image before the first since reset, while status reset is high
    assign accept = state_ff == ST_IDLE && ctrl.srst && en_ff && !fall &&
                    (!sync_ff || ctrl.ocnt != oack_ff) && fill_ff <= ROOM;
    assign loss   = accept && sync_ff && ctrl.ocnt != oack_ff + 2'h1;
    assign wr     = state_ff == ST_LOAD && !fall;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_seg   = seg_ff;
        nxt_len   = len_ff;
        nxt_idx   = idx_ff;
        nxt_cnt   = cnt_ff;
        nxt_oack  = oack_ff;
        nxt_sync  = sync_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_seg  = OUT_IMAGE_I[47:0];
                    nxt_len  = vlen;
                    nxt_idx  = 3'h0;
                    nxt_cnt  = ctrl.ocnt;
                    nxt_sync = 1'b1;
                    if (vlen == 3'h0)
                        nxt_oack = ctrl.ocnt;
                    else
                        nxt_state = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                nxt_seg = {seg_ff[39:0], 8'h00}; // payload byte 0 sits in image byte 5
                nxt_idx = idx_ff + 3'h1;
                // a flush mid-load drops the rest, the segment still counts as taken
                if (fall || idx_ff + 3'h1 == len_ff)
                begin
                    nxt_oack  = cnt_ff;
                    nxt_state = ST_IDLE;
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!NRST_I)
        begin
            state_ff <= ST_IDLE;
            seg_ff   <= 48'h0;
            len_ff   <= 3'h0;
            idx_ff   <= 3'h0;
            cnt_ff   <= 2'h0;
            oack_ff  <= 2'h0;
            sync_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            seg_ff   <= nxt_seg;
            len_ff   <= nxt_len;
            idx_ff   <= nxt_idx;
            cnt_ff   <= nxt_cnt;
            oack_ff  <= nxt_oack;
            sync_ff  <= nxt_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer with a registered output stage
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wp_ff, nxt_wp;
    logic [AW-1:0] rp_ff, nxt_rp;
    logic [CW-1:0] nxt_fill;
    logic [7:0]    txd_ff, nxt_txd;
    logic          txv_ff, nxt_txv;
    logic          pop;
    logic          flush;

    assign flush = fall & txf;
    assign pop   = fill_ff != '0 && (!txv_ff || TX_READY_I);

    always_comb
    begin
        nxt_wp   = wp_ff;
        nxt_rp   = rp_ff;
        nxt_fill = fill_ff;
        nxt_txd  = txd_ff;
        nxt_txv  = txv_ff & ~TX_READY_I;
        if (flush)
        begin
            nxt_wp   = '0;
            nxt_rp   = '0;
            nxt_fill = '0;
            nxt_txv  = 1'b0;
        end
        else
        begin
            if (pop)
            begin
                nxt_txd = mem[rp_ff];
                nxt_txv = 1'b1;
                nxt_rp  = rp_ff + AW'(1);
            end
            if (wr)
                nxt_wp = wp_ff + AW'(1);
            nxt_fill = fill_ff + CW'(wr) - CW'(pop);
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (wr)
            mem[wp_ff] <= seg_ff[47:40];
        if (!NRST_I)
        begin
            wp_ff   <= '0;
            rp_ff   <= '0;
            fill_ff <= '0;
            txd_ff  <= 8'h00;
            txv_ff  <= 1'b0;
        end
        else
        begin
            wp_ff   <= nxt_wp;
            rp_ff   <= nxt_rp;
            fill_ff <= nxt_fill;
            txd_ff  <= nxt_txd;
            txv_ff  <= nxt_txv;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input image: payload, counter and status byte
    logic [47:0] idata_ff;
    logic [2:0]  icount_ff;
    logic [1:0]  icnt_ff;
    stat_byte_t  sbyte;

    always_ff @(posedge CLOCK_I)
    begin
        if (!NRST_I)
        begin
            idata_ff  <= 48'h0;
            icount_ff <= 3'h0;
            icnt_ff   <= 2'h0;
        end
        else if (IN_SEG_I)
        begin
            idata_ff  <= IN_DATA_I;
            icount_ff <= IN_COUNT_I;
            icnt_ff   <= icnt_ff + 2'h1;
        end
    end

    // diagnostics byte is not produced here and reads as zero
    assign sbyte = '{stat: stat_ff, oack: oack_ff, icnt: icnt_ff, ibytes: icount_ff};

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave, sticky events, mask and interrupt
    logic            ack_ff;
    logic [31:0]     dat_ff, nxt_dat;
    logic [EV_W-1:0] evt_ff, nxt_evt, ev_set;
    logic [EV_W-1:0] mask_ff, nxt_mask;
    logic            nxt_en;
    logic            irq_ff;
    logic            req;

    assign req    = CYC_I & STB_I & ~ack_ff;
    assign ev_set = {fall & rxf, flush, COMM_FAULT_I & stat_ff, loss};

    // a read of the event register clears it, but a new event wins
    always_comb
    begin
        nxt_dat  = 32'h0;
        nxt_en   = en_ff;
        nxt_mask = mask_ff;
        nxt_evt  = evt_ff;
        if (req && ADR_I == REG_CTRL)
        begin
            nxt_dat[0] = en_ff;
            if (WE_I && SEL_I[0])
                nxt_en = DAT_I[0];
        end
        else if (req && ADR_I == REG_EVT)
        begin
            nxt_dat[EV_W-1:0] = evt_ff;
            if (!WE_I)
                nxt_evt = '0;
        end
        else if (req && ADR_I == REG_MASK)
        begin
            nxt_dat[EV_W-1:0] = mask_ff;
            if (WE_I && SEL_I[0])
                nxt_mask = DAT_I[EV_W-1:0];
        end
        else if (req && ADR_I == REG_INFO)
        begin
            nxt_dat[INFO_FILL_LSB +: CW] = fill_ff;
            nxt_dat[INFO_OACK_LSB +: 2]  = oack_ff;
            nxt_dat[INFO_STAT_BIT]       = stat_ff;
            nxt_dat[INFO_BUSY_BIT]       = state_ff == ST_LOAD;
        end
        nxt_evt = nxt_evt | ev_set;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!NRST_I)
        begin
            ack_ff  <= 1'b0;
            dat_ff  <= 32'h0;
            en_ff   <= CTRL_EN_RST;
            evt_ff  <= '0;
            mask_ff <= MASK_RST;
            irq_ff  <= 1'b0;
        end
        else
        begin
            ack_ff  <= req; // unmapped offsets also answer, reading zero
            dat_ff  <= nxt_dat;
            en_ff   <= nxt_en;
            evt_ff  <= nxt_evt;
            mask_ff <= nxt_mask;
            irq_ff  <= |(nxt_evt & nxt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign ACK_O      = ack_ff;
    assign DAT_O      = dat_ff;
    assign TX_DATA_O  = txd_ff;
    assign TX_VALID_O = txv_ff;
    assign RX_FLUSH_O = rxfl_ff;
    assign IRQ_O      = irq_ff;
    assign IN_IMAGE_O = {sbyte, 8'h00, idata_ff};

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_tx_flush: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        fall && txf |=> fill_ff == '0 && !txv_ff)
        else $error("transmit buffer not emptied by flush");
    chk_rx_flush: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        fall && rxf |=> RX_FLUSH_O)
        else $error("receive flush missing");
    chk_no_flush: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        !fall |=> !RX_FLUSH_O && fill_ff + CW'(1) >= $past(fill_ff))
        else $error("flush without falling status reset");
    chk_stat_back: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        fall && !COMM_FAULT_I |=> stat_ff)
        else $error("status bit not restored");
    chk_stat_fault: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        COMM_FAULT_I |=> !IN_IMAGE_O[63])
        else $error("status bit not cleared on fault");
    chk_hold_low: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        !ctrl.srst && state_ff == ST_IDLE |=> $stable(oack_ff) && state_ff == ST_IDLE)
        else $error("segment taken while status reset low");
    chk_loss_flag: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        accept && sync_ff && ctrl.ocnt != oack_ff + 2'h1 |=> evt_ff[EV_LOSS])
        else $error("segment loss not flagged");
    chk_ack_copy: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        state_ff == ST_LOAD ##1 state_ff == ST_IDLE |-> IN_IMAGE_O[62:61] == cnt_ff)
        else $error("output segment ack not returned");
    chk_len_max: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        state_ff == ST_LOAD |-> len_ff <= 3'(PAYLOAD_MAX) && idx_ff < len_ff)
        else $error("more than six payload bytes loaded");
    chk_buf_load: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        wr |=> wp_ff == $past(wp_ff) + AW'(1))
        else $error("payload byte not written");
    chk_in_count: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        IN_SEG_I |=> icnt_ff == $past(icnt_ff) + 2'h1)
        else $error("input segment counter did not step");
endmodule
`default_nettype wire

// *** test/seg_ctrl_model.sv ***
// controller side model: owns the output image seen by the receiver
// assumes the bench calls its tasks from one process, single clock
`timescale 1ns/1ns
`default_nettype none
module seg_ctrl_model
    import seg_link_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [63:0] in_image_i,
    output logic      [63:0] out_image_o
);
    ctrl_byte_t  ctl_ff;
    logic [1:0]  iack_ff;
    logic [1:0]  flush_ff;
    logic [47:0] pay_ff;
    ////////////////////////////////////////
    // image: payload bytes, flush byte, control byte
    assign out_image_o = {ctl_ff.srst, iack_ff, ctl_ff.ocnt, ctl_ff.vcnt,
                          6'h00, flush_ff, pay_ff};
    // idle counter 3, so the first real segment steps to 0
    initial
    begin
        ctl_ff = '{1'b1, 2'h0, 2'h3, 3'h0};
        flush_ff = 2'h0;
        pay_ff = 48'h0;
    end
    // echo each input counter back as its acknowledge
    always @(posedge clk_i)
        iack_ff <= in_image_i[60:59];
    // next segment; skip jumps one counter value to fake a lost segment
    task automatic send(input logic skip, input logic [2:0] n, input logic [47:0] p);
        @(posedge clk_i);
        ctl_ff.ocnt <= ctl_ff.ocnt + (skip ? 2'h2 : 2'h1);
        ctl_ff.vcnt <= n;
        pay_ff <= p;
        // held until the acknowledge has had time to return
        repeat (2 + ((n > 3'h6) ? 6 : int'(n))) @(posedge clk_i);
    endtask
    // status reset level together with the flush requests {rx, tx}
    task automatic set_srst(input logic v, input logic [1:0] f);
        @(posedge clk_i);
        ctl_ff.srst <= v;
        flush_ff <= f;
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench of the output segment receiver
// assumes seg_link and the controller model; serial side modelled here
`timescale 1ns/1ns
`default_nettype none
module tb
    import seg_link_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        we = 1'b0;
    logic        req = 1'b0;
    logic        in_seg = 1'b0;
    logic [47:0] in_data = 48'h0;
    logic [2:0]  in_cnt = 3'h0;
    logic        fault = 1'b0;
    logic        rdy = 1'b0;
    logic        stall = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        txv;
    logic        rxf;
    logic        irq;
    logic [7:0]  txd;
    logic [63:0] oimg;
    logic [63:0] iimg;
    logic [7:0]  got_q[$];
    logic [7:0]  exp_q[$];
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          rxf_seen = 0;
    ////////////////////////////////////////
    seg_link #(.DEPTH(128)) i_dut (.CLOCK_I(clk), .NRST_I(nrst), .ADR_I(adr),
        .DAT_I(wdat), .DAT_O(rdat), .WE_I(we), .SEL_I(4'hF), .STB_I(req),
        .CYC_I(req), .ACK_O(ack), .OUT_IMAGE_I(oimg), .IN_SEG_I(in_seg),
        .IN_DATA_I(in_data), .IN_COUNT_I(in_cnt), .COMM_FAULT_I(fault),
        .TX_DATA_O(txd), .TX_VALID_O(txv), .TX_READY_I(rdy), .RX_FLUSH_O(rxf),
        .IN_IMAGE_O(iimg), .IRQ_O(irq));
    seg_ctrl_model i_ctrl (.clk_i(clk), .in_image_i(iimg), .out_image_o(oimg));
    always #10 clk = ~clk;
    // serial side alternates ready so bytes wait; stall holds it off
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        rdy <= stall ? 1'b0 : ~rdy;
        if (txv && rdy)
            got_q.push_back(txd);
        if (rxf)
            rxf_seen <= rxf_seen + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            close_out();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // one classic cycle; a missing ack is left to the cycle limit
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= d;
        req <= 1'b1;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(64'(q), 64'(e));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic want(input logic [2:0] n, input logic [47:0] p);
        for (int i = 0; i < ((n > 3'h6) ? 6 : int'(n)); i++)
            exp_q.push_back(p[47 - 8 * i -: 8]);
    endtask
    task automatic seg(input logic skip, input logic [2:0] n, input logic [47:0] p);
        want(n, p);
        i_ctrl.send(skip, n, p);
        chk(64'(iimg[62:61]), 64'(i_ctrl.ctl_ff.ocnt));
    endtask
    task automatic fin(input string s);
        $display("end of test %s, mismatches %0d", s, fails);
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        chk(iimg, 64'h8000_0000_0000_0000);
        nrst <= 1'b1;
        rd(REG_CTRL, 32'h1);
        rd(REG_MASK, 32'h0);
        rd(8'h10, 32'h0);
        rd(REG_EVT, 32'h0);
        chk(64'(iimg[62:61]), 64'h3);
        fin("reset");
        seg(1'b0, 3'h6, 48'h0102_0304_0506);
        seg(1'b0, 3'h0, 48'hFFFF_FFFF_FFFF);
        seg(1'b0, 3'h7, 48'h2122_2324_2526);
        rd(REG_EVT, 32'h0);
        wr(REG_MASK, 32'h1);
        seg(1'b1, 3'h1, 48'hAA00_0000_0000);
        repeat (2) @(posedge clk);
        chk(64'(irq), 64'h1);
        rd(REG_EVT, 32'h1);
        repeat (2) @(posedge clk);
        chk(64'(irq), 64'h0);
        fin("segments");
        // counter moves while status reset is low: held until it rises
        i_ctrl.set_srst(1'b0, 2'h0);
        i_ctrl.send(1'b0, 3'h3, 48'h1122_3300_0000);
        chk(64'(iimg[62:61]), 64'h0);
        want(3'h3, 48'h1122_3300_0000);
        i_ctrl.set_srst(1'b1, 2'h0);
        repeat (6) @(posedge clk);
        chk(64'(iimg[62:61]), 64'h1);
        fin("held");
        i_ctrl.set_srst(1'b0, 2'h0);
        fault <= 1'b1;
        repeat (3) @(posedge clk);
        chk(64'(iimg[63]), 64'h0);
        fault <= 1'b0;
        i_ctrl.set_srst(1'b1, 2'h3);
        repeat (3) @(posedge clk);
        chk(64'(iimg[63]), 64'h0);
        chk(64'(rxf_seen), 64'h0);
        i_ctrl.set_srst(1'b0, 2'h2);
        repeat (3) @(posedge clk);
        chk(64'(iimg[63]), 64'h1);
        chk(64'(rxf_seen), 64'h1);
        rd(REG_EVT, 32'hA);
        i_ctrl.set_srst(1'b1, 2'h0);
        fin("status");
        // bytes parked behind a stalled line are thrown away
        repeat (100) @(posedge clk);
        stall <= 1'b1;
        i_ctrl.send(1'b0, 3'h5, 48'h5A5A_5A5A_5A00);
        i_ctrl.set_srst(1'b1, 2'h1);
        i_ctrl.set_srst(1'b0, 2'h1);
        repeat (3) @(posedge clk);
        rd(REG_INFO, 32'h0012_0000);
        chk(64'(txv), 64'h0);
        stall <= 1'b0;
        i_ctrl.set_srst(1'b1, 2'h0);
        seg(1'b0, 3'h2, 48'hC3C4_0000_0000);
        rd(REG_EVT, 32'h4);
        repeat (60) @(posedge clk);
        chk(64'(got_q.size()), 64'(exp_q.size()));
        foreach (exp_q[i])
            chk(64'(got_q[i]), 64'(exp_q[i]));
        fin("flush");
        // accept enable off: a new counter waits until it is set again
        wr(REG_CTRL, 32'h0);
        rd(REG_CTRL, 32'h0);
        i_ctrl.send(1'b0, 3'h0, 48'h0);
        chk(64'(iimg[62:61]), 64'h3);
        wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk(64'(iimg[62:61]), 64'h0);
        fin("enable");
        for (int i = 1; i <= 4; i++)
        begin
            @(posedge clk);
            in_seg <= 1'b1;
            in_data <= {16'h0, 32'(i)};
            in_cnt <= 3'(i);
            @(posedge clk);
            in_seg <= 1'b0;
            repeat (2) @(posedge clk);
            chk(iimg, {1'b1, 2'h0, 2'(i), 3'(i), 8'h00, in_data});
        end
        fin("input");
        close_out();
    end
endmodule
`default_nettype wire
